// ---- lft_cfg.svh ----
// lft_cfg.svh: constants of the single-wire frame transmitter and receiver.
// assumes a 100 MHz sys_clk divided down to the timer module clock.
`ifndef LFT_CFG_SVH
`define LFT_CFG_SVH

// ****************************************
// clocking and rate
// ****************************************
`define LFT_SYS_HZ 100000000
`define LFT_MOD_DIV 16
`define LFT_MOD_HZ (`LFT_SYS_HZ / `LFT_MOD_DIV)
`define LFT_BAUD 19200
`define LFT_MAX_BPS 20000
`define LFT_BAUD_DIV (`LFT_MOD_HZ / `LFT_BAUD)
`define LFT_MIN_BAUD_DIV ((`LFT_MOD_HZ + `LFT_MAX_BPS - 1) / `LFT_MAX_BPS)

// ****************************************
// character layout
// ****************************************
`define LFT_BITS_PER_CHAR 8
`define LFT_RX_BITS 10
`define LFT_RX_CMP_HIGH 8'h13
`define LFT_BREAK_BITS 11
`define LFT_IDLE_LEVEL 1'b1
`define LFT_START_LEVEL 1'b0
`define LFT_STOP_LEVEL 1'b1
`define LFT_TOUT_RESET 1'b1

`endif

// ---- lft_pkg.sv ----
// lft_pkg: shared types of the frame transmitter.
// assumes nothing beyond a SystemVerilog compiler.
package lft_pkg;

    typedef logic [7:0] lft_byte_t;

    typedef struct packed {
        logic raw;
        lft_byte_t data;
    } lft_word_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_SHIFT = 2'b10,
        TX_STOP = 2'b11
    } lft_tx_state_t;

endpackage

// ---- lft_stream_if.sv ----
// lft_stream_if: valid/ready word stream between the design's modules.
// assumes one source and one sink on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface lft_stream_if #(
    parameter int WIDTH = 9
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- lft_buffer.sv ----
// lft_buffer: two-entry word buffer with valid and ready on both sides.
// assumes source and sink on sys_clk; ready and valid come from flops.
`timescale 1ns/1ns
`default_nettype none

module lft_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    lft_stream_if.sink in_s,
    lft_stream_if.source out_s
);
    import lft_pkg::*;

    initial begin
        if (DEPTH != 2 || WIDTH < 1) begin
            $error("lft_buffer serves exactly two entries");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic not_full;
    logic not_empty;
    logic push;
    logic pop;
    logic [1:0] next_count;

    assign push = in_s.valid & not_full;
    assign pop = not_empty & out_s.ready;
    assign in_s.ready = not_full;
    assign out_s.valid = not_empty;
    assign out_s.data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    // ****************************************
    // pointers and flags
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            not_full <= 1'b1;
            not_empty <= 1'b0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= next_count;
            not_full <= (next_count != 2'h2);
            not_empty <= (next_count != 2'h0);
        end
    end

endmodule // lft_buffer

`default_nettype wire

// ---- lft_frame_tx.sv ----
// lft_frame_tx: single-wire frame node, dual 8-bit baud timers and shifters.
// assumes software feeds bytes and sets the rate; pin drives a transceiver.
//
// Function
// - frame opens with at least 13 dominant bit periods of break
// - each byte after break: low start, eight data bits, high stop, no parity
// - data bits leave least significant first
// - sync field is one byte of value 0x55
// - header is break, sync, identifier; response is data then checksum
// - master chooses frames by header; slave decides response direction
// - bus rate at most 20 kbit/s; configured for 19200 baud
// - low byte counts module clocks, toggles output and reloads at zero
// - high byte decrements at each low-byte zero, counting shift edges
// - compare high is bits times two minus one, low is divisor/2 minus one
// - empty flag sets on move into shifter, clears on buffer write
// - transmit timer triggers on empty flag low, enables on buffer write
// - timer disables at count zero; stop bit on disable, start on enable
// - timer output is one when enabled; no timer reset
// - transmit shifter changes on rising shift edge; pin active high
// - second timer clocks a second shifter capturing the input pin
// - break plus sync is 0x00, 0xa0, 0xaa sent raw without framing bits
// - break seen after line dominant for 11 local bit times
`timescale 1ns/1ns
`default_nettype none
`include "lft_cfg.svh"

module lft_frame_tx #(
    parameter int MOD_DIV = `LFT_MOD_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr_valid,
    input wire lft_pkg::lft_byte_t wr_data,
    input wire logic wr_raw,
    output logic wr_ready,
    input wire logic [15:0] baud_divisor,
    input wire logic [3:0] bits_per_character,
    output logic rate_error,
    output logic tx_data_pin,
    output logic tx_busy,
    output logic tx_buffer_empty,
    input wire logic rx_pin,
    output lft_pkg::lft_byte_t rx_data,
    output logic rx_valid,
    output logic rx_frame_error,
    output logic rx_break
);
    import lft_pkg::*;

    initial begin
        if (MOD_DIV < 1 || MOD_DIV > 65536) begin
            $error("lft_frame_tx: MOD_DIV out of range");
        end
    end

    // ****************************************
    // module clock tick and compare value
    // ****************************************
    logic [15:0] pre_cnt;
    logic tick;
    logic [7:0] cmp_low;
    logic [7:0] cmp_high;
    logic [14:0] half_div;

    assign tick = clk_en && (pre_cnt == 16'h0000);
    assign half_div = baud_divisor[15:1];
    assign cmp_low = 8'(half_div - 15'h0001);
    assign cmp_high = 8'({4'h0, bits_per_character} * 8'h02 - 8'h01);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (pre_cnt == 16'h0000) begin
                pre_cnt <= 16'(MOD_DIV - 1);
            end else begin
                pre_cnt <= pre_cnt - 16'h0001;
            end
        end
    end

    // too fast, or low byte cannot hold the half divisor
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_error <= 1'b0;
        end else if (clk_en) begin
            rate_error <= (baud_divisor < 16'(`LFT_MIN_BAUD_DIV))
                || (half_div > 15'h0100) || (half_div == 15'h0000)
                || (bits_per_character == 4'h0)
                || (bits_per_character > 4'(`LFT_BITS_PER_CHAR));
        end
    end

    // ****************************************
    // write buffer and single-word holding register
    // ****************************************
    lft_stream_if #(.WIDTH(9)) in_if ();
    lft_stream_if #(.WIDTH(9)) out_if ();

    assign in_if.valid = wr_valid;
    assign in_if.data = {wr_raw, wr_data};
    assign wr_ready = in_if.ready;

    lft_buffer #(
        .WIDTH(9),
        .DEPTH(2)
    ) u_buffer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_s(in_if.sink),
        .out_s(out_if.source)
    );

    lft_word_t shift_buffer_word;
    logic buf_empty;
    logic tx_load;

    // only pulled while the holding register is empty, so load and fill
    // never meet in one cycle
    assign out_if.ready = buf_empty;
    assign tx_buffer_empty = buf_empty;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_buffer_word <= '0;
            buf_empty <= 1'b1;
        end else if (clk_en) begin
            if (tx_load) begin
                buf_empty <= 1'b1;
            end else if (buf_empty && out_if.valid) begin
                shift_buffer_word <= out_if.data;
                buf_empty <= 1'b0;
            end
        end
    end

    // ****************************************
    // transmit timer and shifter
    // ****************************************
    lft_tx_state_t tx_state;
    logic [7:0] tx_low;
    logic [7:0] tx_high;
    logic tx_tout;
    logic [7:0] tx_shift;
    logic tx_raw;
    logic tx_phase_end;
    logic tx_compare;

    assign tx_phase_end = tick && (tx_low == 8'h00) && (tx_high == 8'h00);
    assign tx_compare = (tx_state == TX_SHIFT) && tx_phase_end;

    // raw words chain at compare so the break stays unbroken
    always_comb begin
        tx_load = 1'b0;
        if (!buf_empty && !rate_error) begin
            if (tx_state == TX_IDLE) begin
                tx_load = 1'b1;
            end else if (tx_compare && tx_raw && shift_buffer_word.raw) begin
                tx_load = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_low <= 8'h00;
            tx_high <= 8'h00;
            tx_tout <= `LFT_TOUT_RESET;
            tx_shift <= 8'h00;
            tx_raw <= 1'b0;
            tx_data_pin <= `LFT_IDLE_LEVEL;
            tx_busy <= 1'b0;
        end else if (clk_en) begin
            if (tx_load) begin
                tx_tout <= 1'b1;
                tx_low <= cmp_low;
                tx_raw <= shift_buffer_word.raw;
                tx_busy <= 1'b1;
                if (shift_buffer_word.raw) begin
                    tx_state <= TX_SHIFT;
                    tx_high <= cmp_high;
                    tx_data_pin <= shift_buffer_word.data[0];
                    tx_shift <= {1'b0, shift_buffer_word.data[7:1]};
                end else begin
                    tx_state <= TX_START;
                    tx_high <= 8'h01;
                    tx_data_pin <= `LFT_START_LEVEL;
                    tx_shift <= shift_buffer_word.data;
                end
            end else begin
                case (tx_state)
                    TX_IDLE: begin
                        tx_tout <= 1'b1;
                        tx_busy <= 1'b0;
                        tx_data_pin <= `LFT_IDLE_LEVEL;
                    end
                    TX_START: begin
                        if (tick && tx_low != 8'h00) begin
                            tx_low <= tx_low - 8'h01;
                        end else if (tick) begin
                            tx_low <= cmp_low;
                            tx_high <= tx_high - 8'h01;
                            if (tx_high == 8'h00) begin
                                tx_state <= TX_SHIFT;
                                tx_high <= cmp_high;
                                tx_data_pin <= tx_shift[0];
                                tx_shift <= {1'b0, tx_shift[7:1]};
                            end
                        end
                    end
                    TX_SHIFT: begin
                        if (tick && tx_low != 8'h00) begin
                            tx_low <= tx_low - 8'h01;
                        end else if (tick) begin
                            tx_low <= cmp_low;
                            tx_tout <= ~tx_tout;
                            tx_high <= tx_high - 8'h01;
                            if (tx_high == 8'h00) begin
                                tx_tout <= 1'b1;
                                tx_low <= cmp_low;
                                tx_high <= 8'h01;
                                tx_data_pin <= `LFT_STOP_LEVEL;
                                tx_state <= tx_raw ? TX_IDLE : TX_STOP;
                            end else if (!tx_tout) begin
                                tx_data_pin <= tx_shift[0];
                                tx_shift <= {1'b0, tx_shift[7:1]};
                            end
                        end
                    end
                    TX_STOP: begin
                        tx_data_pin <= `LFT_STOP_LEVEL;
                        if (tick && tx_low != 8'h00) begin
                            tx_low <= tx_low - 8'h01;
                        end else if (tick) begin
                            tx_low <= cmp_low;
                            tx_high <= tx_high - 8'h01;
                            if (tx_high == 8'h00) begin
                                tx_state <= TX_IDLE;
                            end
                        end
                    end
                    default: begin
                        tx_state <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // receive pin synchroniser
    // ****************************************
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_level;
    logic rx_level_d;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_s1 <= `LFT_IDLE_LEVEL;
            rx_s2 <= `LFT_IDLE_LEVEL;
            rx_s3 <= `LFT_IDLE_LEVEL;
            rx_level <= `LFT_IDLE_LEVEL;
            rx_level_d <= `LFT_IDLE_LEVEL;
        end else if (clk_en) begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_level <= rx_s3;
            end
            rx_level_d <= rx_level;
        end
    end

    // ****************************************
    // receive timer and shifter
    // ****************************************
    logic rx_active;
    logic [7:0] rx_low;
    logic [7:0] rx_high;
    logic rx_tout;
    logic [`LFT_RX_BITS-1:0] rx_shift;
    logic [`LFT_RX_BITS-1:0] rx_next_shift;

    assign rx_next_shift = {rx_level, rx_shift[`LFT_RX_BITS-1:1]};

    // samples land on falling shift edges, mid-bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_active <= 1'b0;
            rx_low <= 8'h00;
            rx_high <= 8'h00;
            rx_tout <= `LFT_TOUT_RESET;
            rx_shift <= '0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_frame_error <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= 1'b0;
            if (!rx_active) begin
                if (rx_level_d && !rx_level && !rate_error) begin
                    rx_active <= 1'b1;
                    rx_low <= cmp_low;
                    rx_high <= `LFT_RX_CMP_HIGH;
                    rx_tout <= 1'b1;
                end
            end else if (tick && rx_low != 8'h00) begin
                rx_low <= rx_low - 8'h01;
            end else if (tick) begin
                rx_low <= cmp_low;
                rx_tout <= ~rx_tout;
                rx_high <= rx_high - 8'h01;
                if (rx_tout) begin
                    rx_shift <= rx_next_shift;
                end
                if (rx_high == 8'h00) begin
                    rx_active <= 1'b0;
                    rx_data <= rx_shift[8:1];
                    rx_frame_error <= (rx_shift[9] != `LFT_STOP_LEVEL);
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // break detector
    // ****************************************
    logic [8:0] brk_tick_cnt;
    logic [3:0] brk_bit_cnt;
    logic brk_seen;

    // a bit time is two low-byte periods
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            brk_tick_cnt <= 9'h000;
            brk_bit_cnt <= 4'h0;
            brk_seen <= 1'b0;
            rx_break <= 1'b0;
        end else if (clk_en) begin
            rx_break <= 1'b0;
            if (rx_level) begin
                brk_tick_cnt <= 9'h000;
                brk_bit_cnt <= 4'h0;
                brk_seen <= 1'b0;
            end else if (tick && !brk_seen) begin
                if (brk_tick_cnt == {cmp_low, 1'b1}) begin
                    brk_tick_cnt <= 9'h000;
                    brk_bit_cnt <= brk_bit_cnt + 4'h1;
                    if (brk_bit_cnt == 4'(`LFT_BREAK_BITS - 1)) begin
                        brk_seen <= 1'b1;
                        rx_break <= 1'b1;
                    end
                end else begin
                    brk_tick_cnt <= brk_tick_cnt + 9'h001;
                end
            end
        end
    end

endmodule // lft_frame_tx

`default_nettype wire

// ---- lft_frame_tx_sva.sv ----
// lft_frame_tx_sva: port-level checks of the frame transmitter.
// assumes a bind onto lft_frame_tx with clk_en held high.
`timescale 1ns/1ns
`default_nettype none

module lft_frame_tx_sva #(
    parameter int MOD_DIV = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [15:0] baud_divisor,
    input wire logic rate_error,
    input wire logic tx_data_pin,
    input wire logic tx_busy,
    input wire logic tx_buffer_empty,
    input wire logic rx_pin,
    input wire logic rx_valid,
    input wire logic rx_break
);
    // ****************
    // helpers
    // ****************
    logic [31:0] low_run;
    logic [31:0] rx_low;
    logic [31:0] bit_cyc;
    // one bit is two half periods of divisor/2 module ticks
    assign bit_cyc = 32'(baud_divisor[15:1]) * 32'(2 * MOD_DIV);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst || tx_data_pin) begin
            low_run <= 32'h0;
        end else begin
            low_run <= low_run + 32'h1;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst || rx_pin) begin
            rx_low <= 32'h0;
        end else begin
            rx_low <= rx_low + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************
    // properties
    // ****************
    a_idle_high: assert property (!tx_busy |-> tx_data_pin)
        else $error("line not high while idle");
    a_empty_set: assert property ($rose(tx_busy) |-> tx_buffer_empty)
        else $error("empty flag not set on load");
    a_busy_cause: assert property ($rose(tx_busy) |-> $past(!tx_buffer_empty))
        else $error("char started without a held word");
    a_load_walk: assert property ((clk_en && wr_valid && wr_ready && !tx_busy
        && tx_buffer_empty && !rate_error && !$past(wr_valid))
        |-> ##2 !tx_buffer_empty ##1 (tx_busy && tx_buffer_empty))
        else $error("write did not start the timer in time");
    a_low_bits: assert property ($rose(tx_data_pin)
        |-> low_run != 0 && low_run % bit_cyc == 0)
        else $error("low run not a whole number of bits");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid longer than one cycle");
    a_brk_pulse: assert property (rx_break |=> !rx_break)
        else $error("rx_break longer than one cycle");
    a_brk_wait: assert property ($rose(rx_break)
        |-> rx_low >= 32'd11 * bit_cyc && rx_low < 32'd12 * bit_cyc)
        else $error("break flagged at wrong low length");
    a_rate_hold: assert property (rate_error && !tx_busy |=> !tx_busy)
        else $error("char started under rate error");
    c_tx_load: cover property ($rose(tx_busy));
    c_rx_byte: cover property (rx_valid);
    c_rx_break: cover property (rx_break);
    c_full: cover property (!wr_ready);
endmodule // lft_frame_tx_sva

bind lft_frame_tx lft_frame_tx_sva #(.MOD_DIV(MOD_DIV)) u_sva (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .baud_divisor(baud_divisor), .rate_error(rate_error),
    .tx_data_pin(tx_data_pin), .tx_busy(tx_busy), .tx_buffer_empty(tx_buffer_empty),
    .rx_pin(rx_pin), .rx_valid(rx_valid), .rx_break(rx_break));

`default_nettype wire

// ---- lft_bus_model.sv ----
// lft_bus_model: transceiver plus one remote node on a wired-and line.
// assumes the bench calls send() just after a rising sys_clk edge.
`timescale 1ns/1ns
`default_nettype none

module lft_bus_model #(
    parameter int BIT_CYC = 324
) (
    input wire logic sys_clk,
    input wire logic tx_line,
    output logic rx_line
);
    logic remote;
    // pull-up bus: dominant low wins, released line reads high
    assign rx_line = tx_line & remote;
    initial remote = 1'b1;
    // ****************
    // remote node
    // ****************
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            remote <= f[i];
            repeat (BIT_CYC) @(posedge sys_clk);
        end
        remote <= 1'b1;
    endtask
endmodule // lft_bus_model

`default_nettype wire

// ---- lft_frame_tx_tb_top.sv ----
// lft_frame_tx_tb_top: self-checking bench for the frame transmitter.
// assumes MOD_DIV of 1 and divisor 325, so one bit lasts 324 clocks.
`timescale 1ns/1ns
`default_nettype none

module lft_frame_tx_tb_top;
    import lft_pkg::*;
    localparam int BIT = 324;
    logic sys_clk, rst, clk_en, wr_valid, wr_raw, wr_ready, rate_error, tx_data_pin;
    logic tx_busy, tx_buffer_empty, rx_pin, rx_valid, rx_frame_error, rx_break, brk_seen;
    lft_byte_t wr_data, rx_data;
    logic [15:0] baud_divisor;
    logic [3:0] bits_per_character;
    int n_mismatch = 0;
    int cmp_count = 0;

    lft_frame_tx #(.MOD_DIV(1)) u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_raw(wr_raw), .wr_ready(wr_ready),
        .baud_divisor(baud_divisor), .bits_per_character(bits_per_character),
        .rate_error(rate_error), .tx_data_pin(tx_data_pin), .tx_busy(tx_busy),
        .tx_buffer_empty(tx_buffer_empty), .rx_pin(rx_pin), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_frame_error(rx_frame_error), .rx_break(rx_break));
    lft_bus_model #(.BIT_CYC(BIT)) u_bus (.sys_clk(sys_clk), .tx_line(tx_data_pin),
        .rx_line(rx_pin));

    // ****************
    // tasks
    // ****************
    task automatic close_out;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic miss(input string m);
        n_mismatch++;
        $display("CHECK FAILED t=%0t %s", $time, m);
    endtask
    task automatic chk_byte(input lft_byte_t g, input lft_byte_t e, input string m);
        cmp_count++;
        if (g !== e) miss(m);
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        cmp_count++;
        if (g !== e) miss(m);
    endtask
    function automatic logic sel(input int w);
        return (w == 0) ? tx_data_pin : (w == 1) ? wr_ready : rx_valid;
    endfunction
    // reads the value sampled at the edge just passed
    task automatic wait_lvl(input int w, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (sel(w) !== v && n < lim);
        if (sel(w) !== v) begin
            miss("wait ran out");
            close_out();
        end
    endtask
    // holds the request until ready is seen; caller lowers wr_valid
    task automatic wr(input lft_byte_t d, input logic raw);
        wr_data <= d;
        wr_raw <= raw;
        wr_valid <= 1'b1;
        wait_lvl(1, 1'b1, 5000);
    endtask
    task automatic cap(input lft_byte_t e, input string m);
        lft_byte_t v;
        wait_lvl(0, 1'b0, 8 * BIT);
        repeat (BIT / 2) @(posedge sys_clk);
        chk_bit(tx_data_pin, 1'b0, "start bit");
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge sys_clk);
            v[i] = tx_data_pin;
        end
        repeat (BIT) @(posedge sys_clk);
        chk_bit(tx_data_pin, 1'b1, "stop bit");
        chk_byte(v, e, m);
    endtask
    task automatic send_cap(input lft_byte_t d);
        fork
            begin
                wr(d, 1'b0);
                wr_valid <= 1'b0;
            end
            cap(d, "framed byte");
        join
    endtask
    task automatic remote(input lft_byte_t d, input logic stop);
        fork
            u_bus.send(d, stop);
            wait_lvl(2, 1'b1, 12 * BIT);
        join
        chk_byte(rx_data, d, "received byte");
        chk_bit(rx_frame_error, !stop, "frame error flag");
    endtask
    task automatic cap_break;
        int n;
        wait_lvl(0, 1'b0, 8 * BIT);
        n = 0;
        do begin
            n++;
            @(posedge sys_clk);
        end while (tx_data_pin === 1'b0 && n < 20 * BIT);
        chk_bit(n >= 13 * BIT && n < 14 * BIT, 1'b1, "break length");
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // one driver only: reset and set both live here
    always @(posedge sys_clk) begin
        brk_seen <= (rst === 1'b1) ? 1'b0 : (brk_seen | (rx_break === 1'b1));
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        miss("run too long");
        close_out();
    end
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        wr_valid = 1'b0;
        wr_raw = 1'b0;
        wr_data = 8'h00;
        baud_divisor = 16'h0145;
        bits_per_character = 4'h8;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        chk_bit(tx_data_pin, 1'b1, "line after reset");
        chk_bit(tx_buffer_empty, 1'b1, "empty after reset");
        chk_bit(tx_busy, 1'b0, "busy after reset");
        fork
            begin
                wr(8'h00, 1'b1);
                wr(8'ha0, 1'b1);
                wr(8'haa, 1'b1);
                wr(8'h3c, 1'b0);
                wr_valid <= 1'b0;
                repeat (3) @(posedge sys_clk);
                chk_bit(wr_ready, 1'b0, "buffer full");
                wr(8'h01, 1'b0);
                wr(8'h80, 1'b0);
                wr(8'h7e, 1'b0);
                wr_valid <= 1'b0;
            end
            begin
                cap_break();
                cap(8'h55, "sync");
                cap(8'h3c, "identifier");
                cap(8'h01, "data 0");
                cap(8'h80, "data 1");
                cap(8'h7e, "checksum");
            end
        join
        wait_lvl(2, 1'b1, 2 * BIT);
        chk_byte(rx_data, 8'h7e, "echo of checksum");
        chk_bit(brk_seen, 1'b1, "break not seen");
        chk_bit(tx_buffer_empty, 1'b1, "drained");
        for (int k = 0; k < 3; k++) begin
            baud_divisor <= (k == 0) ? 16'h0138 : 16'h0145;
            bits_per_character <= (k == 1) ? 4'h0 : (k == 2) ? 4'h9 : 4'h8;
            repeat (3) @(posedge sys_clk);
            chk_bit(rate_error, 1'b1, "rate not flagged");
        end
        wr(8'hc3, 1'b0);
        wr_valid <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk_bit(tx_busy, 1'b0, "started under error");
        bits_per_character <= 4'h8;
        cap(8'hc3, "held byte");
        chk_bit(rate_error, 1'b0, "rate error stuck");
        // let the echo of the held byte finish before the remote talks
        wait_lvl(2, 1'b1, 2 * BIT);
        chk_byte(rx_data, 8'hc3, "echo of held byte");
        remote(8'h3a, 1'b1);
        remote(8'hc5, 1'b0);
        wr(8'h0f, 1'b0);
        wr_valid <= 1'b0;
        repeat (BIT) @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        chk_bit(tx_data_pin, 1'b1, "line in reset");
        chk_bit(tx_busy, 1'b0, "busy in reset");
        rst <= 1'b0;
        send_cap(8'h96);
        close_out();
    end
endmodule // lft_frame_tx_tb_top

`default_nettype wire
